// ==== pkg/fsup_pkg.sv ====
package fsup_pkg;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DEB_SHORT_NS = 20000;
    localparam int unsigned DEB_SHORT_CYC = (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROT_WIN_NS = 1000000;
    localparam int unsigned PROT_WIN_CYC = (PROT_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EN_SAMPLE_NS = 3000;
    localparam int unsigned EN_SAMPLE_CYC = EN_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned OTP_LOAD_CYC = 8;
    localparam int unsigned CNT_W = 17;
    localparam int unsigned NUM_CORES = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    // Control word layout
    localparam int unsigned CTRL_EN_LSB = 0;
    localparam int unsigned CTRL_PIN_LSB = 4;
    localparam int unsigned CTRL_DIS_LSB = 8;
    localparam int unsigned CTRL_WSEL_BIT = 12;
    localparam int unsigned CTRL_W = 13;

    // Flag word layout, also used by the mask word except that mask bit 1 masks the reset flag
    localparam int unsigned FLG_WARN_BIT = 0;
    localparam int unsigned FLG_SD_BIT = 1;
    localparam int unsigned FLG_RST_BIT = 2;
    localparam int unsigned FLG_SHORT_LSB = 4;
    localparam int unsigned FLG_SUM_LSB = 8;
    localparam int unsigned MSK_W = 8;

    // Status word layout
    localparam int unsigned ST_WARN_BIT = 0;
    localparam int unsigned ST_SD_BIT = 1;
    localparam int unsigned ST_RUN_LSB = 4;
    localparam int unsigned ST_MODE_LSB = 8;
    localparam int unsigned ST_ILIM_LSB = 16;
    localparam int unsigned ST_PG_LSB = 20;

    // Reset and one-time-programmed values
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
    localparam logic [CTRL_W-1:0] CTRL_OTP = 13'h0fff;
    localparam logic [MSK_W-1:0] MSK_RST = 8'h00;

    typedef enum logic [4:0] {
        M_OFF = 5'h01,
        M_BIAS = 5'h02,
        M_OTP = 5'h04,
        M_IDLE = 5'h08,
        M_RUN = 5'h10
    } mode_t;

    typedef enum logic [2:0] {
        C_OFF = 3'h1,
        C_START = 3'h2,
        C_RUN = 3'h4
    } core_st_t;
endpackage

// ==== pkg/filt_if.sv ====
`timescale 1ns/10ps
interface filt_if;
    logic raw;
    logic clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ==== rtl/deb_filter.sv ====
`timescale 1ns/10ps
module deb_filter import fsup_pkg::*; #(
    parameter int unsigned WIN_CYC = 2
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n, // Synced reset, active low
    filt_if.filt lane // Raw in, filtered out
);
    typedef struct packed {
        logic clean;
        logic [CNT_W-1:0] cnt;
    } deb_t;
    deb_t q, d;

    // Output flips only after the raw level held for the whole window
    always_comb begin
        d = q;
        if (lane.raw == q.clean) begin
            d.cnt = '0;
        end else if (q.cnt == CNT_W'(WIN_CYC - 1)) begin
            d.clean = lane.raw;
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lane.clean = q.clean;
endmodule // deb_filter

// ==== rtl/core_guard.sv ====
`timescale 1ns/10ps
module core_guard import fsup_pkg::*; #(
    parameter int unsigned START_CYC = 2
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n, // Synced reset, active low
    input wire logic i_req, // Core wanted on and allowed
    input wire logic i_fb_low, // Raw output below short level
    input wire logic i_ovl, // Filtered overload level
    output logic o_active, // Core switching
    output logic o_run, // Start-up done, regulating
    output logic o_fault // Short or overload, one pulse
);
    typedef struct packed {
        core_st_t st;
        logic [CNT_W-1:0] cnt;
    } guard_t;
    guard_t q, d;

    // Start window, then watch for overload while regulating
    always_comb begin
        d = q;
        o_fault = 1'b0;
        case (q.st)
            C_OFF: begin
                d.cnt = '0;
                if (i_req) begin
                    d.st = C_START;
                end
            end
            C_START: begin
                d.cnt = q.cnt + 1'b1;
                if (!i_req) begin
                    d.st = C_OFF;
                end else if (q.cnt == CNT_W'(START_CYC - 1)) begin
                    d.cnt = '0;
                    if (i_fb_low) begin // [R4]
                        o_fault = 1'b1;
                        d.st = C_OFF;
                    end else begin
                        d.st = C_RUN;
                    end
                end
            end
            C_RUN: begin
                if (!i_req) begin
                    d.st = C_OFF;
                end else if (i_ovl) begin // [R5]
                    o_fault = 1'b1;
                    d.st = C_OFF;
                end
            end
            default: begin
                d.st = C_OFF;
                d.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{st: C_OFF, cnt: '0};
        end else begin
            q <= d;
        end
    end

    assign o_active = (q.st != C_OFF);
    assign o_run = (q.st == C_RUN);
endmodule // core_guard

// ==== rtl/fault_supervisor.sv ====
`timescale 1ns/10ps
// Overview of operation
// [R1] Selectable warning threshold sets flag, asserts irq
// [R2] Live warning visible; write one clears flag
// [R3] Disabled core: stage off, discharge if enabled
// [R4] Output low at 1 ms: short disable
// [R5] Feedback low 1 ms while running: overload disable
// [R6] Short sets flags, clears running, asserts irq
// [R7] Clearing short flag retries wanted core
// [R8] Thermal shutdown: all off, flag, irq, idle
// [R9] Shutdown clear ignored while condition persists
// [R10] No enabling during shutdown or pending flag
// [R11] Undervoltage: all off, discharge, off state
// [R12] Leaving off state sets reset flag
// [R13] Inputs debounced by counter, one clock accuracy
// [R14] Enable pins only synchronised, 3 us sampling
// [R15] 20 us filter on thermal, limit, power-good
// [R16] 1 ms filter on overload detection
// [R17] Off until release high, then bias up
// [R18] OTP load with cores disabled
// [R19] Idle ready: cores off, registers open
// [R20] Running whenever any core enabled
// [R21] Irq held while any unmasked flag pending
// [R22] Masked flags still set, not irq
module fault_supervisor import fsup_pkg::*; #(
    parameter int unsigned PROT_CYC = PROT_WIN_CYC
) (
    input wire logic i_sys_clk, // 100 MHz clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic [7:0] i_address, // Avalon byte address
    input wire logic i_read, // Avalon read
    input wire logic i_write, // Avalon write
    input wire logic [31:0] i_writedata, // Avalon write data
    input wire logic [3:0] i_byteenable, // Avalon byte lanes
    output logic [31:0] o_readdata, // Avalon read data
    output logic o_waitrequest, // Avalon wait
    input wire logic i_power_on_release, // Release pin level
    input wire logic i_supply_ok, // Analog supply above lockout
    input wire logic i_temp_warn_lo, // Die above low warn level
    input wire logic i_temp_warn_hi, // Die above high warn level
    input wire logic i_temp_sd, // Die above shutdown level
    input wire logic [3:0] i_enable_pin, // Per-core enable pins
    input wire logic [3:0] i_fb_low, // Feedback below 0.35 V
    input wire logic [3:0] i_current_limit, // Peak limit active
    input wire logic [3:0] i_power_good, // Output reached target
    output logic o_irq_n, // Interrupt, active low
    output logic [3:0] o_core_on, // Power stage switching
    output logic [3:0] o_core_hiz, // Power stage high impedance
    output logic [3:0] o_discharge_on // Output pulldown on
);
    localparam int unsigned NL = 14;
    localparam int unsigned NS = 10;

    typedef struct packed {
        mode_t mode;
        logic [3:0] otp_cnt;
        logic [8:0] en_cnt;
        logic [3:0] en_m;
        logic [3:0] en_s;
        logic [3:0] en_q;
        logic [CTRL_W-1:0] ctrl;
        logic [MSK_W-1:0] msk;
        logic warn_f;
        logic sd_f;
        logic rst_f;
        logic [3:0] short_f;
        logic wait_q;
        logic [31:0] rdata;
        logic irq_n;
        logic [3:0] core_on;
        logic [3:0] hiz;
        logic [3:0] dis;
    } sup_t;
    sup_t q, d;

    logic rst_m_q;
    logic rst_s_q;
    logic [NL-1:0] raw_vec;
    logic [NL-1:0] clean_vec;
    logic [3:0] core_req;
    logic [3:0] core_act;
    logic [3:0] core_run;
    logic [3:0] core_flt;
    logic warn_live;
    logic sd_live;
    logic [3:0] ilim_live;
    logic [3:0] pg_live;
    logic [3:0] ovl_live;

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // Warning comparator picked before filtering, so a threshold change is also debounced
    assign raw_vec[0] = q.ctrl[CTRL_WSEL_BIT] ? i_temp_warn_hi : i_temp_warn_lo; // [R1]
    assign raw_vec[1] = i_temp_sd;
    assign raw_vec[5:2] = i_current_limit;
    assign raw_vec[9:6] = i_power_good;
    // Overload watch only while regulating; an idle or ramping output is low by nature
    assign raw_vec[13:10] = i_fb_low & core_run; // [R5] [R16]

    // One counter filter per lane: short window lanes, then overload lanes
    filt_if lane_if [NL] ();
    for (genvar i = 0; i < NL; i++) begin : g_lane
        assign lane_if[i].raw = raw_vec[i];
        assign clean_vec[i] = lane_if[i].clean;
        deb_filter #(
            .WIN_CYC(i < NS ? DEB_SHORT_CYC : PROT_CYC) // [R15] [R16]
        ) u_deb (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(rst_s_q),
            .lane(lane_if[i]) // [R13]
        );
    end

    assign warn_live = clean_vec[0];
    assign sd_live = clean_vec[1];
    assign ilim_live = clean_vec[5:2];
    assign pg_live = clean_vec[9:6];
    assign ovl_live = clean_vec[13:10];

    // Per-core start window and overload watch
    for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
        core_guard #(
            .START_CYC(PROT_CYC)
        ) u_guard (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(rst_s_q),
            .i_req(core_req[c]),
            .i_fb_low(i_fb_low[c]),
            .i_ovl(ovl_live[c]),
            .o_active(core_act[c]),
            .o_run(core_run[c]),
            .o_fault(core_flt[c])
        );
    end

    // Enable request: register bit, optionally gated by the sampled pin
    always_comb begin
        logic allow;
        allow = 1'b0;
        allow = ((q.mode == M_IDLE) || (q.mode == M_RUN)) && !sd_live && !q.sd_f; // [R10] [R19]
        for (int c = 0; c < NUM_CORES; c++) begin
            core_req[c] = allow && !q.short_f[c] && i_supply_ok && i_power_on_release // [R7] [R11]
                && q.ctrl[CTRL_EN_LSB + c] && (!q.ctrl[CTRL_PIN_LSB + c] || q.en_q[c]);
        end
    end

    // Main next-state logic
    always_comb begin
        logic [31:0] be_m;
        logic [31:0] wmask;
        logic acc;
        logic wr;
        logic [MSK_W-1:0] pend;
        be_m = '0;
        wmask = '0;
        acc = 1'b0;
        wr = 1'b0;
        pend = '0;
        d = q;

        // Mode sequencing; losing supply or release wins from any mode
        case (q.mode)
            M_OFF: begin
                if (i_power_on_release) begin // [R17]
                    d.mode = M_BIAS;
                end
            end
            M_BIAS: begin
                if (i_supply_ok) begin
                    d.mode = M_OTP;
                    d.otp_cnt = '0;
                end
            end
            M_OTP: begin
                d.otp_cnt = q.otp_cnt + 1'b1;
                d.ctrl = CTRL_OTP; // [R18]
                if (q.otp_cnt == 4'(OTP_LOAD_CYC - 1)) begin
                    d.mode = M_IDLE;
                end
            end
            M_IDLE: begin
                if (|core_act) begin // [R20]
                    d.mode = M_RUN;
                end
            end
            M_RUN: begin
                if (!(|core_act)) begin // [R8]
                    d.mode = M_IDLE;
                end
            end
            default: begin
                d.mode = M_OFF;
            end
        endcase
        if (!i_supply_ok || !i_power_on_release) begin // [R11]
            d.mode = M_OFF;
        end

        // Enable pins: two-stage sync, then sampled every 3 us with no filtering
        d.en_m = i_enable_pin;
        d.en_s = q.en_m;
        if (q.en_cnt == 9'(EN_SAMPLE_CYC - 1)) begin
            d.en_cnt = '0;
            d.en_q = q.en_s; // [R14]
        end else begin
            d.en_cnt = q.en_cnt + 1'b1;
        end

        // Bus: one wait cycle, answer on the cycle waitrequest is low
        acc = (i_read || i_write) && q.wait_q;
        wr = i_write && !q.wait_q;
        d.wait_q = !acc;
        for (int b = 0; b < 4; b++) begin
            be_m[8*b +: 8] = {8{i_byteenable[b]}};
        end
        wmask = i_writedata & be_m;
        if (wr && i_address == ADDR_CTRL) begin
            d.ctrl = (q.ctrl & ~be_m[CTRL_W-1:0]) | wmask[CTRL_W-1:0];
        end
        if (wr && i_address == ADDR_MASK) begin
            d.msk = (q.msk & ~be_m[MSK_W-1:0]) | wmask[MSK_W-1:0];
        end
        if (wr && i_address == ADDR_FLAGS) begin
            if (wmask[FLG_WARN_BIT] && !warn_live) begin // [R2]
                d.warn_f = 1'b0;
            end
            if (wmask[FLG_SD_BIT] && !sd_live) begin // [R9]
                d.sd_f = 1'b0;
            end
            if (wmask[FLG_RST_BIT]) begin // [R12]
                d.rst_f = 1'b0;
            end
            d.short_f = q.short_f & ~wmask[FLG_SHORT_LSB +: 4]; // [R7]
        end

        // Sets come after clears, so an event in the clear cycle is kept
        if (warn_live) begin
            d.warn_f = 1'b1; // [R1] [R22]
        end
        if (sd_live) begin
            d.sd_f = 1'b1; // [R8]
        end
        d.short_f = d.short_f | core_flt; // [R6]
        if (q.mode == M_OTP && d.mode == M_IDLE) begin
            d.rst_f = 1'b1; // [R12]
        end

        // Off state holds control, mask and the warning, shutdown and short flags at their cleared values; the reset flag keeps its value
        if (d.mode == M_OFF) begin
            d.ctrl = CTRL_RST;
            d.msk = MSK_RST;
            d.warn_f = 1'b0;
            d.sd_f = 1'b0;
            d.short_f = '0;
        end

        // Interrupt: unmasked pending flags; shutdown has no mask
        pend[0] = d.warn_f && !d.msk[0]; // [R22]
        pend[1] = d.rst_f && !d.msk[1];
        pend[2] = d.sd_f;
        pend[7:4] = d.short_f & ~d.msk[7:4];
        d.irq_n = !(|pend); // [R21]

        // Read data, registered ahead of the answer cycle
        d.rdata = '0;
        if (acc && i_read) begin
            case (i_address)
                ADDR_CTRL: d.rdata[CTRL_W-1:0] = q.ctrl;
                ADDR_MASK: d.rdata[MSK_W-1:0] = q.msk;
                ADDR_FLAGS: begin
                    d.rdata[FLG_WARN_BIT] = q.warn_f;
                    d.rdata[FLG_SD_BIT] = q.sd_f;
                    d.rdata[FLG_RST_BIT] = q.rst_f;
                    d.rdata[FLG_SHORT_LSB +: 4] = q.short_f;
                    d.rdata[FLG_SUM_LSB +: 4] = q.short_f; // [R6]
                end
                ADDR_STATUS: begin
                    d.rdata[ST_WARN_BIT] = warn_live; // [R2]
                    d.rdata[ST_SD_BIT] = sd_live; // [R9]
                    d.rdata[ST_RUN_LSB +: 4] = core_run; // [R6]
                    d.rdata[ST_MODE_LSB +: 5] = q.mode;
                    d.rdata[ST_ILIM_LSB +: 4] = ilim_live;
                    d.rdata[ST_PG_LSB +: 4] = pg_live;
                end
                default: d.rdata = '0;
            endcase
        end

        // Stage drive; pulldowns forced while the supply is lost
        d.core_on = core_act & core_req;
        d.hiz = ~d.core_on; // [R3]
        for (int c = 0; c < NUM_CORES; c++) begin
            d.dis[c] = !d.core_on[c] && (d.ctrl[CTRL_DIS_LSB + c] || d.mode == M_OFF); // [R3] [R11]
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            q <= '0;
            q.mode <= M_OFF;
            q.ctrl <= CTRL_RST;
            q.msk <= MSK_RST;
            q.wait_q <= 1'b1;
            q.irq_n <= 1'b1;
            q.hiz <= 4'hf;
            q.dis <= 4'hf;
        end else begin
            q <= d;
        end
    end

    assign o_readdata = q.rdata;
    assign o_waitrequest = q.wait_q;
    assign o_irq_n = q.irq_n;
    assign o_core_on = q.core_on;
    assign o_core_hiz = q.hiz;
    assign o_discharge_on = q.dis;
endmodule // fault_supervisor

// ==== dv/fsup_props.sv ====
`timescale 1ns/10ps
module fsup_props import fsup_pkg::*; #(
    parameter int unsigned PROT_CYC = 50
) (
    input wire logic i_sys_clk, // Clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_read, // Bus read
    input wire logic i_write, // Bus write
    input wire logic [31:0] o_readdata, // Bus read data
    input wire logic o_waitrequest, // Bus wait
    input wire logic i_power_on_release, // Release pin
    input wire logic i_supply_ok, // Supply above lockout
    input wire logic i_temp_sd, // Die above shutdown level
    input wire logic [3:0] i_fb_low, // Feedback low
    input wire logic o_irq_n, // Interrupt
    input wire logic [3:0] o_core_on, // Stage switching
    input wire logic [3:0] o_core_hiz, // Stage high impedance
    input wire logic [3:0] o_discharge_on // Pulldown on
);
    logic [11:0] sd_cnt_q; // Cycles of shutdown input high
    logic [19:0] fb_cnt_q; // Cycles core 0 on with feedback low
    // Saturating helpers, so a long hot spell never wraps to zero
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sd_cnt_q <= 12'h000;
            fb_cnt_q <= 20'h00000;
        end else begin
            sd_cnt_q <= !i_temp_sd ? 12'h000 : sd_cnt_q + {11'h000, sd_cnt_q != 12'hfff};
            fb_cnt_q <= !(i_fb_low[0] && o_core_on[0]) ? 20'h00000 : fb_cnt_q + {19'h00000, fb_cnt_q != 20'hfffff};
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    property p_hiz; o_core_hiz == ~o_core_on; endproperty
    property p_dis_off; (o_core_on & o_discharge_on) == 4'h0; endproperty
    property p_uv; !i_supply_ok |-> ##[1:4] (o_core_on == 4'h0 && o_discharge_on == 4'hf); endproperty
    property p_rel; !i_power_on_release |-> ##[1:4] o_core_on == 4'h0; endproperty
    property p_ack; (i_read || i_write) && o_waitrequest |=> !o_waitrequest; endproperty
    property p_gap; !o_waitrequest |=> o_waitrequest; endproperty
    property p_rdz; o_waitrequest |-> o_readdata == 32'h0; endproperty
    property p_sd_off; sd_cnt_q > 12'h7e4 |-> o_core_on == 4'h0; endproperty
    property p_sd_irq; sd_cnt_q > 12'h7e4 |-> !o_irq_n; endproperty
    property p_fb; 32'(fb_cnt_q) > PROT_CYC + 8 |-> !o_core_on[0]; endproperty
    a_hiz: assert property (p_hiz) else $error("stage not high impedance while off");
    a_dis_off: assert property (p_dis_off) else $error("pulldown on while core runs");
    a_uv: assert property (p_uv) else $error("cores kept on at undervoltage");
    a_rel: assert property (p_rel) else $error("cores kept on with release low");
    a_ack: assert property (p_ack) else $error("bus answer missing");
    a_gap: assert property (p_gap) else $error("wait low for more than one cycle");
    a_rdz: assert property (p_rdz) else $error("read data outside answer cycle");
    a_sd_off: assert property (p_sd_off) else $error("core on during shutdown");
    a_sd_irq: assert property (p_sd_irq) else $error("no interrupt at shutdown");
    a_fb: assert property (p_fb) else $error("core not stopped on low feedback");
    c_start: cover property ($rose(o_core_on[0]));
    c_fault: cover property ($fell(o_core_on[0]) && i_fb_low[0]);
    c_irq: cover property ($fell(o_irq_n));
endmodule // fsup_props
bind fault_supervisor fsup_props #(.PROT_CYC(PROT_CYC)) u_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_power_on_release(i_power_on_release), .i_supply_ok(i_supply_ok), .i_temp_sd(i_temp_sd),
    .i_fb_low(i_fb_low), .o_irq_n(o_irq_n), .o_core_on(o_core_on), .o_core_hiz(o_core_hiz),
    .o_discharge_on(o_discharge_on));

// ==== dv/stage_model.sv ====
`timescale 1ns/10ps
module stage_model (
    input wire logic i_sys_clk, // Clock
    input wire logic [3:0] i_core_on, // Stage switching
    input wire logic [3:0] i_short, // Bench forces output short
    output logic [3:0] o_fb_low, // Output below short level
    output logic [3:0] o_power_good // Output at target
);
    logic [3:0] ramp_q [4]; // Soft-start progress per core
    // Output ramps while switching, collapses at once when off
    always_ff @(posedge i_sys_clk) begin
        for (int c = 0; c < 4; c++) begin
            ramp_q[c] <= !i_core_on[c] ? 4'h0 : ramp_q[c] + {3'h0, ramp_q[c] != 4'hf};
        end
    end
    // A short holds the output low whatever the ramp says
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            o_fb_low[c] = i_short[c] || ramp_q[c] < 4'h4;
            o_power_good[c] = !i_short[c] && ramp_q[c] == 4'hf;
        end
    end
endmodule // stage_model

// ==== dv/fault_supervisor_test.sv ====
`timescale 1ns/10ps
module fault_supervisor_test import fsup_pkg::*;;
    localparam int unsigned PCYC = 50;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rel = 1'b1, sup = 1'b1;
    logic wlo = 1'b0, whi = 1'b0, tsd = 1'b0, waitr, irq_n;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] enp = 4'h0, shrt = 4'h0, ilim = 4'h0, fbl, pg, on, hiz, dis;
    int fails = 0, comparisons = 0;
    always #5 clk = ~clk; // 100 MHz
    // Short windows keep the run brief; expectations follow PCYC
    fault_supervisor #(.PROT_CYC(PCYC)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_address(adr), .i_read(rd),
        .i_write(wr), .i_writedata(wdat), .i_byteenable(4'hf), .o_readdata(rdat), .o_waitrequest(waitr),
        .i_power_on_release(rel), .i_supply_ok(sup), .i_temp_warn_lo(wlo), .i_temp_warn_hi(whi),
        .i_temp_sd(tsd), .i_enable_pin(enp), .i_fb_low(fbl), .i_current_limit(ilim), .i_power_good(pg),
        .o_irq_n(irq_n), .o_core_on(on), .o_core_hiz(hiz), .o_discharge_on(dis));
    stage_model u_stage (.i_sys_clk(clk), .i_core_on(on), .i_short(shrt), .o_fb_low(fbl), .o_power_good(pg));
    task automatic finish_test;
        $display("Checks: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bus cycle; request held until wait is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (waitr !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, q & m, e);
    endtask
    // Poll mode until idle; bounded so a stuck sequencer ends the run
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (q[12:8] !== M_IDLE && n < 60);
        if (n >= 60) begin
            fails++;
            finish_test();
        end
    endtask
    initial begin
        wait_cyc(3);
        rst_n <= 1'b1;
        wait_cyc(2); // First request from the third edge after release
        wait_idle();
        rchk("otp ctrl", ADDR_CTRL, 32'h1fff, 32'h0fff);
        rchk("reset flag", ADDR_FLAGS, 32'hfff, 32'h4);
        check("irq reset", {31'h0, irq_n}, 32'h0);
        check("idle off", {28'h0, on}, 32'h0);
        rchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
        bus(1'b1, ADDR_FLAGS, 32'h4);
        rchk("reset clr", ADDR_FLAGS, 32'hfff, 32'h0);
        check("irq free", {31'h0, irq_n}, 32'h1);
        $display("Test reset done");
        enp <= 4'h1;
        wait_cyc(320);
        check("pin on", {28'h0, on}, 32'h1);
        wait_cyc(PCYC + 20);
        rchk("run mode", ADDR_STATUS, 32'h1ff0, 32'h1010);
        $display("Test pin done");
        shrt <= 4'h1;
        wait_cyc(PCYC + 20);
        rchk("short flag", ADDR_FLAGS, 32'hfff, 32'h110);
        rchk("run clear", ADDR_STATUS, 32'hf0, 32'h0);
        check("stage", {20'h0, dis, hiz, on}, 32'hff0);
        check("irq short", {31'h0, irq_n}, 32'h0);
        shrt <= 4'h0;
        wait_cyc(PCYC + 20);
        bus(1'b1, ADDR_FLAGS, 32'h10);
        wait_cyc(10);
        check("retry", {27'h0, on, irq_n}, 32'h3);
        $display("Test short done");
        bus(1'b1, ADDR_MASK, 32'h10);
        shrt <= 4'h1;
        wait_cyc(PCYC + 20);
        rchk("masked flag", ADDR_FLAGS, 32'hfff, 32'h110);
        check("masked irq", {31'h0, irq_n}, 32'h1);
        shrt <= 4'h0;
        wait_cyc(PCYC + 20);
        bus(1'b1, ADDR_FLAGS, 32'h10);
        bus(1'b1, ADDR_MASK, 32'h0);
        $display("Test mask done");
        bus(1'b1, ADDR_CTRL, 32'h1fff);
        wlo <= 1'b1;
        ilim <= 4'h5;
        wait_cyc(2100);
        rchk("warn lo", ADDR_FLAGS, 32'h1, 32'h0);
        whi <= 1'b1;
        wait_cyc(1990);
        rchk("warn early", ADDR_FLAGS, 32'h1, 32'h0);
        wait_cyc(100);
        rchk("warn set", ADDR_FLAGS, 32'hfff, 32'h1);
        check("irq warn", {31'h0, irq_n}, 32'h0);
        rchk("live", ADDR_STATUS, 32'hff0001, 32'h150001);
        bus(1'b1, ADDR_FLAGS, 32'h1);
        rchk("warn kept", ADDR_FLAGS, 32'hfff, 32'h1);
        whi <= 1'b0;
        wlo <= 1'b0;
        wait_cyc(2100);
        bus(1'b1, ADDR_FLAGS, 32'h1);
        rchk("warn clr", ADDR_FLAGS, 32'hfff, 32'h0);
        $display("Test warn done");
        tsd <= 1'b1;
        wait_cyc(2100);
        check("sd stage", {27'h0, irq_n, on}, 32'h0);
        bus(1'b1, ADDR_FLAGS, 32'h2);
        rchk("sd kept", ADDR_FLAGS, 32'hfff, 32'h2);
        rchk("sd idle", ADDR_STATUS, 32'h1f02, 32'h0802);
        tsd <= 1'b0;
        wait_cyc(2100);
        check("sd pend", {28'h0, on}, 32'h0);
        bus(1'b1, ADDR_FLAGS, 32'h2);
        wait_cyc(10);
        rchk("sd clr", ADDR_FLAGS, 32'hfff, 32'h0);
        check("sd resume", {28'h0, on}, 32'h1);
        $display("Test shutdown done");
        sup <= 1'b0;
        wait_cyc(5);
        check("uv stage", {24'h0, dis, on}, 32'hf0);
        sup <= 1'b1;
        rel <= 1'b0;
        enp <= 4'h0;
        wait_cyc(5);
        check("rel off", {28'h0, on}, 32'h0);
        // Pin dropped and resampled, so no core starts and idle can be seen
        wait_cyc(310);
        rel <= 1'b1;
        wait_idle();
        rchk("uv reset", ADDR_FLAGS, 32'hfff, 32'h4);
        rchk("uv ctrl", ADDR_CTRL, 32'h1fff, 32'h0fff);
        $display("Test supply done");
        finish_test();
    end
endmodule // fault_supervisor_test
